// ==== verification/host_port_model.sv ====
`timescale 1ns/1ns
module host_port_model (
    // Clock.
    input wire logic clk,
    // Port pins.
    output logic sleep_config_pin,
    output logic sclk,
    output logic strobe,
    output logic data
);
    initial begin
        sleep_config_pin = 1'b1;
        sclk = 1'b0;
        strobe = 1'b0;
        data = 1'b0;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rest(input logic s);
        hold(1);
        sleep_config_pin <= s;
        hold(4);
    endtask
    // Each level stands four cycles so the three-stage synchronisers see it.
    task automatic send(input logic [15:0] w, input logic to_mon);
        hold(1);
        for (int i = 15; i >= 0; i--) begin
            data <= w[i];
            hold(4);
            sclk <= 1'b1;
            hold(4);
            sclk <= 1'b0;
            hold(4);
        end
        data <= to_mon;
        hold(4);
        strobe <= 1'b1;
        hold(4);
        strobe <= 1'b0;
        data <= ~to_mon;
        hold(4);
    endtask
endmodule

// ==== verification/monitor_cfg_checker.sv ====
`timescale 1ns/1ns
module monitor_cfg_checker (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Pins.
    input wire logic sleep_config_pin,
    input wire logic first_port_clock_line,
    input wire logic first_port_strobe_line,
    input wire logic first_port_data_line,
    // Status sources.
    input wire monitor_cfg_pkg::reg_faults_t reg_faults,
    input wire logic motor_overcurrent,
    input wire logic thermal_trip,
    input wire logic warm_warning,
    input wire logic osc_clock,
    // Watched outputs.
    input wire logic [15:0] setup_word,
    input wire logic setup_write,
    input wire monitor_cfg_pkg::monitor_cfg_t cfg,
    input wire monitor_cfg_pkg::test_mode_t test_mode,
    input wire logic osc_monitor_en,
    input wire logic temperature_sense_signal_en,
    input wire logic [2:0] regulator_shutdown,
    input wire logic motor_shutdown,
    input wire logic thermal_shutdown,
    input wire logic fault_reset_output_n,
    input wire logic monitor_out
);
    logic [8:0] f;
    logic [5:0] grp;
    logic gsel;
    logic th_exp;
    assign f = reg_faults;
    assign grp = {|f[2:0], |f[5:3], |f[8:6], f[8] | f[5] | f[2], f[7] | f[4] | f[1],
        f[6] | f[3] | f[0]};
    assign gsel = grp[cfg.monitor_signal_selector[2:0]];
    assign th_exp = thermal_trip & ~cfg.ignore_thermal_trip;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_RESET_ZERO: assert property ($rose(reset_n) |-> cfg == 16'h0000)
        else $error("monitoring register not zero after reset");
    AST_TEST_DECODE: assert property (test_mode == ((cfg[15:13] > 3'h3) ? 3'h0 : cfg[15:13]))
        else $error("test mode decode wrong");
    AST_OSC_EN: assert property (osc_monitor_en == (cfg.test_select_field == 3'h3))
        else $error("oscillator monitor enable wrong");
    AST_WARM_ROUTE: assert property (temperature_sense_signal_en == cfg.warm_output_route)
        else $error("warm route wrong");
    AST_SEL_GROUPS: assert property (clk_en && cfg.monitor_signal_selector < 4'h6 |=>
        monitor_out == $past(gsel)) else $error("fault group on monitor pin wrong");
    AST_SETUP_STEER: assert property (setup_write |-> $stable(cfg))
        else $error("setup word disturbed monitoring register");
    AST_SLEEP_GATE: assert property ($changed(cfg) |-> $past(sleep_config_pin, 4) == 1'b0)
        else $error("monitoring register written while awake");
    AST_THERMAL_IGNORE: assert property (clk_en |=> thermal_shutdown == $past(th_exp))
        else $error("thermal shutdown ignore wrong");
    AST_REG_SHUTDOWN: assert property (clk_en && f[6] && !cfg.ignore_regulator_overcurrent
        |=> regulator_shutdown[0]) else $error("channel A not shut down");
    AST_NO_RESET_SET: assert property (clk_en && f == 9'h040 && !motor_overcurrent
        && !thermal_trip && !cfg.ignore_regulator_overcurrent && cfg.no_fault_reset[2]
        |=> fault_reset_output_n) else $error("blocked channel pulled fault reset");
    AST_NO_RESET_CLR: assert property (clk_en && f == 9'h040 && !cfg.no_fault_reset[2]
        && !cfg.ignore_regulator_overcurrent |=> !fault_reset_output_n)
        else $error("fault reset not pulled");
    cover property (setup_write);
    cover property ($changed(cfg));
    cover property (!fault_reset_output_n);
endmodule
bind extended_monitor_config monitor_cfg_checker chk_u (.clk(clk), .reset_n(reset_n),
    .clk_en(clk_en), .sleep_config_pin(sleep_config_pin),
    .first_port_clock_line(first_port_clock_line),
    .first_port_strobe_line(first_port_strobe_line),
    .first_port_data_line(first_port_data_line), .reg_faults(reg_faults),
    .motor_overcurrent(motor_overcurrent), .thermal_trip(thermal_trip),
    .warm_warning(warm_warning), .osc_clock(osc_clock), .setup_word(setup_word),
    .setup_write(setup_write), .cfg(cfg), .test_mode(test_mode),
    .osc_monitor_en(osc_monitor_en), .temperature_sense_signal_en(temperature_sense_signal_en),
    .regulator_shutdown(regulator_shutdown), .motor_shutdown(motor_shutdown),
    .thermal_shutdown(thermal_shutdown), .fault_reset_output_n(fault_reset_output_n),
    .monitor_out(monitor_out));

// ==== verification/tb.sv ====
`timescale 1ns/1ns
module tb;
    typedef struct packed {
        logic [15:0] w;
        logic mon;
        logic [2:0] md;
    } row_t;
    // Channel B overvoltage is the only fault while the rows run; codes above three are normal.
    row_t rows [10] = '{'{16'h0000, 1'b0, 3'h0}, '{16'h2001, 1'b1, 3'h1}, '{16'h4002, 1'b0, 3'h2},
        '{16'h6003, 1'b0, 3'h3}, '{16'h0004, 1'b1, 3'h0}, '{16'hA00E, 1'b1, 3'h0},
        '{16'hE00F, 1'b1, 3'h0}, '{16'h8006, 1'b0, 3'h0},
        '{16'h000B, monitor_cfg_pkg::MAKER_ID[0], 3'h0}, '{16'h1005, 1'b0, 3'h0}};
    logic clk, reset_n, sleep, sclk, strobe, data, tt, setup_write, osc_en, ts_en, th_sd, frn, mon;
    logic en, moc, ww, msd;
    logic [15:0] setup_pulses = 16'h0000;
    logic [15:0] setup_word;
    logic [2:0] reg_sd;
    monitor_cfg_pkg::reg_faults_t faults;
    monitor_cfg_pkg::monitor_cfg_t cfg;
    monitor_cfg_pkg::test_mode_t mode;
    int fails, tests_run;
    host_port_model host_u (.clk(clk), .sleep_config_pin(sleep), .sclk(sclk), .strobe(strobe),
        .data(data));
    extended_monitor_config dut_u (.clk(clk), .reset_n(reset_n), .clk_en(en),
        .sleep_config_pin(sleep), .first_port_clock_line(sclk), .first_port_strobe_line(strobe),
        .first_port_data_line(data), .reg_faults(faults), .motor_overcurrent(moc),
        .thermal_trip(tt), .warm_warning(ww), .osc_clock(1'b0), .setup_word(setup_word),
        .setup_write(setup_write), .cfg(cfg), .test_mode(mode), .osc_monitor_en(osc_en),
        .temperature_sense_signal_en(ts_en), .regulator_shutdown(reg_sd), .motor_shutdown(msd),
        .thermal_shutdown(th_sd), .fault_reset_output_n(frn), .monitor_out(mon));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // The setup strobe stands one cycle only, so every pulse is counted here.
    always @(posedge clk) begin
        if (setup_write === 1'b1) begin
            setup_pulses <= setup_pulses + 16'h0001;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic put(input logic [15:0] w, input logic to_mon);
        host_u.send(w, to_mon);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d bad %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge clk);
        fails++;
        give_verdict();
    end
    initial begin
        reset_n = 1'b0;
        tt = 1'b0;
        en = 1'b1;
        moc = 1'b0;
        ww = 1'b0;
        faults = 9'h000;
        fails = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        faults <= 9'h010;
        @(posedge clk);
        #1;
        chk(cfg, 16'h0000);
        $display("test reset done");
        host_u.rest(1'b0);
        foreach (rows[i]) begin
            put(rows[i].w, 1'b1);
            chk(cfg, rows[i].w);
            chk(mode, rows[i].md);
            chk(osc_en, rows[i].md == 3'h3);
            chk(ts_en, rows[i].w[12]);
            chk(mon, rows[i].mon);
        end
        $display("test rows done");
        put(16'ha5a5, 1'b0);
        chk(setup_word, 16'ha5a5);
        chk(cfg, 16'h1005);
        chk(setup_pulses, 16'h0001);
        host_u.rest(1'b1);
        put(16'hffff, 1'b1);
        chk(cfg, 16'h1005);
        chk(setup_word, 16'ha5a5);
        chk(setup_pulses, 16'h0001);
        host_u.rest(1'b0);
        $display("test steer done");
        @(posedge clk);
        ww <= 1'b1;
        put(16'h0007, 1'b1);
        chk(mon, 1'b1);
        put(16'h1007, 1'b1);
        chk(mon, 1'b0);
        chk(ts_en, 1'b1);
        @(posedge clk);
        ww <= 1'b0;
        faults <= 9'h040;
        put(16'h0400, 1'b1);
        chk(frn, 1'b1);
        chk(reg_sd, 3'h1);
        put(16'h0000, 1'b1);
        chk(frn, 1'b0);
        @(posedge clk);
        faults <= 9'h000;
        moc <= 1'b1;
        put(16'h0006, 1'b1);
        chk(mon, 1'b1);
        chk(msd, 1'b1);
        chk(frn, 1'b0);
        put(16'h0040, 1'b1);
        chk(msd, 1'b0);
        chk(frn, 1'b1);
        @(posedge clk);
        moc <= 1'b0;
        tt <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(th_sd, 1'b1);
        put(16'h0080, 1'b1);
        chk(th_sd, 1'b0);
        $display("test faults done");
        // A whole frame sent while the enable is low must leave the register alone.
        @(posedge clk);
        en <= 1'b0;
        put(16'h1234, 1'b1);
        chk(cfg, 16'h0080);
        @(posedge clk);
        en <= 1'b1;
        $display("test freeze done");
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(cfg, 16'h0000);
        $display("test second reset done");
        give_verdict();
    end
endmodule

// ==== verilog/extended_monitor_config.sv ====
`timescale 1ns/1ns
// How it works
// - Host writes this register on the first port while sleep is low, data high.
// - Data low at strobe rise sends the word to setup; this register stays.
// - Bits 15:13 choose normal, trip control one, trip control two, oscillator monitor.
// - Bit 12 clear shows warm warning on monitor pin; set routes temperature sense.
// - Bits 3:0 select the internal signal driven on the monitor pin.
// - Bits 10:8 block fault reset per regulator; bits 7:4 ignore shutdown sources.
// - Strobe starts low, sixteen or more clocks, data sampled on falling clock.
// - Selector codes 0 to 5 give ORed regulator fault groups.
// - A blocked channel still shuts down but does not pull fault reset.
module extended_monitor_config (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Serial port and sleep pin.
    input wire logic sleep_config_pin,
    input wire logic first_port_clock_line,
    input wire logic first_port_strobe_line,
    input wire logic first_port_data_line,
    // Internal status sources.
    input wire monitor_cfg_pkg::reg_faults_t reg_faults,
    input wire logic motor_overcurrent,
    input wire logic thermal_trip,
    input wire logic warm_warning,
    input wire logic osc_clock,
    // Setup register handoff.
    output logic [15:0] setup_word,
    output logic setup_write,
    // Configuration and protection outputs.
    output monitor_cfg_pkg::monitor_cfg_t cfg,
    output monitor_cfg_pkg::test_mode_t test_mode,
    output logic osc_monitor_en,
    output logic temperature_sense_signal_en,
    output logic [2:0] regulator_shutdown,
    output logic motor_shutdown,
    output logic thermal_shutdown,
    output logic fault_reset_output_n,
    output logic monitor_out
);
    // Three flops per pin; edges use only the second and third stages.
    logic [2:0] sclk_s_q;
    logic [2:0] strb_s_q;
    logic [2:0] data_s_q;
    logic [2:0] sleep_s_q;
    logic [2:0] osc_s_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sclk_s_q <= 3'h0;
            strb_s_q <= 3'h0;
            data_s_q <= 3'h0;
            sleep_s_q <= 3'h7;
            osc_s_q <= 3'h0;
        end else if (clk_en) begin
            sclk_s_q <= {sclk_s_q[1:0], first_port_clock_line};
            strb_s_q <= {strb_s_q[1:0], first_port_strobe_line};
            data_s_q <= {data_s_q[1:0], first_port_data_line};
            sleep_s_q <= {sleep_s_q[1:0], sleep_config_pin};
            osc_s_q <= {osc_s_q[1:0], osc_clock};
        end
    end

    logic sclk_fall;
    logic strobe_rise;
    logic port_open;
    assign sclk_fall = sclk_s_q[2] & ~sclk_s_q[1];
    assign strobe_rise = ~strb_s_q[2] & strb_s_q[1];
    assign port_open = ~sleep_s_q[1] & ~sleep_s_q[2];

    logic [15:0] shift_word;
    logic word_valid;
    logic word_to_monitor;

    serial_shift_in #(
        .WIDTH(monitor_cfg_pkg::WORD_BITS)
    ) u_shift (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .sclk_fall(sclk_fall),
        .strobe_rise(strobe_rise),
        .data_bit(data_s_q[1]),
        .word_q(shift_word),
        .word_valid(word_valid),
        .word_to_monitor(word_to_monitor)
    );

    // Word register and setup handoff.
    logic [15:0] cfg_q;
    logic [15:0] cfg_d;
    logic [15:0] setup_q;
    logic [15:0] setup_d;
    logic setup_wr_d;
    logic setup_wr_q;

    always_comb begin
        cfg_d = cfg_q;
        setup_d = setup_q;
        setup_wr_d = 1'b0;
        if (word_valid && port_open) begin
            if (word_to_monitor) begin
                cfg_d = shift_word;
            end else begin
                setup_d = shift_word;
                setup_wr_d = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q <= monitor_cfg_pkg::CFG_RESET;
            setup_q <= 16'h0000;
            setup_wr_q <= 1'b0;
        end else if (clk_en) begin
            cfg_q <= cfg_d;
            setup_q <= setup_d;
            setup_wr_q <= setup_wr_d;
        end
    end

    assign cfg = monitor_cfg_pkg::monitor_cfg_t'(cfg_q);
    assign setup_word = setup_q;
    assign setup_write = setup_wr_q;

    // Test mode decode; unlisted codes fall back to normal for safety.
    always_comb begin
        case (cfg.test_select_field)
            3'h1: test_mode = monitor_cfg_pkg::TEST_TRIP_CTRL1;
            3'h2: test_mode = monitor_cfg_pkg::TEST_TRIP_CTRL2;
            3'h3: test_mode = monitor_cfg_pkg::TEST_OSC_MON;
            default: test_mode = monitor_cfg_pkg::TEST_NORMAL;
        endcase
    end
    assign osc_monitor_en = (test_mode == monitor_cfg_pkg::TEST_OSC_MON);
    assign temperature_sense_signal_en = cfg.warm_output_route;

    // Protection paths. Ignoring a source can damage the part if held long.
    logic [2:0] chan_fault;
    logic [2:0] reg_oc_eff;
    logic [2:0] reg_sup_eff;
    logic [2:0] reset_cause;
    logic any_reset_d;
    logic any_reset_q;
    logic [2:0] shut_q;
    logic motor_shut_q;
    logic thermal_shut_q;

    always_comb begin
        reg_oc_eff = reg_faults.overcurrent & {3{~cfg.ignore_regulator_overcurrent}};
        reg_sup_eff = (reg_faults.overvoltage | reg_faults.undervoltage)
            & {3{~cfg.ignore_regulator_supervisor}};
        chan_fault = reg_oc_eff | reg_sup_eff;
        // Bit 10 serves channel A, bit 8 channel C.
        reset_cause = chan_fault & ~{cfg.no_fault_reset[0], cfg.no_fault_reset[1],
            cfg.no_fault_reset[2]};
        any_reset_d = |reset_cause
            | (thermal_trip & ~cfg.ignore_thermal_trip)
            | (motor_overcurrent & ~cfg.ignore_motor_overcurrent);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shut_q <= 3'h0;
            motor_shut_q <= 1'b0;
            thermal_shut_q <= 1'b0;
            any_reset_q <= 1'b0;
        end else if (clk_en) begin
            shut_q <= chan_fault;
            motor_shut_q <= motor_overcurrent & ~cfg.ignore_motor_overcurrent;
            thermal_shut_q <= thermal_trip & ~cfg.ignore_thermal_trip;
            any_reset_q <= any_reset_d;
        end
    end

    assign regulator_shutdown = shut_q;
    assign motor_shutdown = motor_shut_q;
    assign thermal_shutdown = thermal_shut_q;
    assign fault_reset_output_n = ~any_reset_q;

    // Monitor pin selection, registered.
    logic mon_d;
    logic mon_q;

    always_comb begin
        case (cfg.monitor_signal_selector)
            monitor_cfg_pkg::SEL_FAULT_A: mon_d = reg_faults.overcurrent[0]
                | reg_faults.overvoltage[0] | reg_faults.undervoltage[0];
            monitor_cfg_pkg::SEL_FAULT_B: mon_d = reg_faults.overcurrent[1]
                | reg_faults.overvoltage[1] | reg_faults.undervoltage[1];
            monitor_cfg_pkg::SEL_FAULT_C: mon_d = reg_faults.overcurrent[2]
                | reg_faults.overvoltage[2] | reg_faults.undervoltage[2];
            monitor_cfg_pkg::SEL_OVERCUR: mon_d = |reg_faults.overcurrent;
            monitor_cfg_pkg::SEL_OVERVOLT: mon_d = |reg_faults.overvoltage;
            monitor_cfg_pkg::SEL_UNDERVOLT: mon_d = |reg_faults.undervoltage;
            monitor_cfg_pkg::SEL_MOTOR_OC: mon_d = motor_overcurrent;
            // The warm warning is ORed with the trip flag here unless routed to analog.
            monitor_cfg_pkg::SEL_THERMAL: mon_d = cfg.warm_output_route
                ? thermal_trip : (thermal_trip | warm_warning);
            monitor_cfg_pkg::SEL_REV0: mon_d = monitor_cfg_pkg::REVISION_ID[0];
            monitor_cfg_pkg::SEL_REV1: mon_d = monitor_cfg_pkg::REVISION_ID[1];
            monitor_cfg_pkg::SEL_REV2: mon_d = monitor_cfg_pkg::REVISION_ID[2];
            monitor_cfg_pkg::SEL_MAKER0: mon_d = monitor_cfg_pkg::MAKER_ID[0];
            monitor_cfg_pkg::SEL_MAKER1: mon_d = monitor_cfg_pkg::MAKER_ID[1];
            monitor_cfg_pkg::SEL_OSC: mon_d = osc_s_q[2];
            default: mon_d = 1'b1;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mon_q <= 1'b0;
        end else if (clk_en) begin
            mon_q <= mon_d;
        end
    end

    assign monitor_out = mon_q;
endmodule

// ==== verilog/monitor_cfg_pkg.sv ====
package monitor_cfg_pkg;

    localparam int unsigned WORD_BITS = 16;
    localparam logic [15:0] CFG_RESET = 16'h0000;

    // Field positions of the monitoring register.
    localparam int unsigned TEST_SEL_HI = 15;
    localparam int unsigned TEST_SEL_LO = 13;
    localparam int unsigned WARM_ROUTE_BIT = 12;
    localparam int unsigned WARM_THRESH_BIT = 11;
    localparam int unsigned NO_RESET_HI = 10;
    localparam int unsigned NO_RESET_LO = 8;
    localparam int unsigned IGNORE_HI = 7;
    localparam int unsigned IGNORE_LO = 4;
    localparam int unsigned SEL_HI = 3;
    localparam int unsigned SEL_LO = 0;

    // Signal selector codes.
    localparam logic [3:0] SEL_FAULT_A = 4'h0;
    localparam logic [3:0] SEL_FAULT_B = 4'h1;
    localparam logic [3:0] SEL_FAULT_C = 4'h2;
    localparam logic [3:0] SEL_OVERCUR = 4'h3;
    localparam logic [3:0] SEL_OVERVOLT = 4'h4;
    localparam logic [3:0] SEL_UNDERVOLT = 4'h5;
    localparam logic [3:0] SEL_MOTOR_OC = 4'h6;
    localparam logic [3:0] SEL_THERMAL = 4'h7;
    localparam logic [3:0] SEL_REV0 = 4'h8;
    localparam logic [3:0] SEL_REV1 = 4'h9;
    localparam logic [3:0] SEL_REV2 = 4'hA;
    localparam logic [3:0] SEL_MAKER0 = 4'hB;
    localparam logic [3:0] SEL_MAKER1 = 4'hC;
    localparam logic [3:0] SEL_OSC = 4'hD;

    // Arbitrary identity values, not those of any real part.
    localparam logic [2:0] REVISION_ID = 3'h0;
    localparam logic [1:0] MAKER_ID = 2'h0;

    typedef enum logic [2:0] {
        TEST_NORMAL = 3'h0,
        TEST_TRIP_CTRL1 = 3'h1,
        TEST_TRIP_CTRL2 = 3'h2,
        TEST_OSC_MON = 3'h3
    } test_mode_t;

    typedef struct packed {
        logic [2:0] test_select_field;
        logic warm_output_route;
        logic warm_threshold;
        logic [2:0] no_fault_reset;
        logic ignore_thermal_trip;
        logic ignore_motor_overcurrent;
        logic ignore_regulator_supervisor;
        logic ignore_regulator_overcurrent;
        logic [3:0] monitor_signal_selector;
    } monitor_cfg_t;

    // Per-channel regulator fault flags, index 0 is channel A.
    typedef struct packed {
        logic [2:0] overcurrent;
        logic [2:0] overvoltage;
        logic [2:0] undervoltage;
    } reg_faults_t;

endpackage

// ==== verilog/serial_shift_in.sv ====
`timescale 1ns/1ns
module serial_shift_in #(
    parameter int unsigned WIDTH = 16
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Synchronised port lines.
    input wire logic sclk_fall,
    input wire logic strobe_rise,
    input wire logic data_bit,
    // Captured word.
    output logic [WIDTH-1:0] word_q,
    output logic word_valid,
    output logic word_to_monitor
);
    logic [WIDTH-1:0] shift_q;
    logic [WIDTH-1:0] shift_d;

    always_comb begin
        shift_d = shift_q;
        if (sclk_fall) begin
            shift_d = {shift_q[WIDTH-2:0], data_bit};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_q <= '0;
        end else if (clk_en) begin
            shift_q <= shift_d;
        end
    end

    assign word_q = shift_q;
    assign word_valid = strobe_rise;
    // The data line level at the strobe edge picks the destination.
    assign word_to_monitor = data_bit;
endmodule
